//--- hw/sasl_pkg.sv
package sasl_pkg;
    // ************************************************************
    // widths
    // ************************************************************
    localparam int unsigned DATA_W      = 64;
    localparam int unsigned FIFO_DEPTH  = 32;
    localparam int unsigned BLK_W       = 66;
    localparam logic [1:0]  HDR_DATA    = 2'h1;
    localparam logic [1:0]  HDR_CTRL    = 2'h2;
    localparam logic [7:0]  BT_IDLE     = 8'h78;
    localparam logic [7:0]  BT_COMP     = 8'h55;
    localparam logic [7:0]  BT_SEP      = 8'h1e;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned GEAR_PERIOD   = 32;
    localparam int unsigned COMP_PERIOD   = 4992;
    localparam int unsigned COMP_LEN      = 8;
    localparam int unsigned COMP_MIN      = 3;
    localparam int unsigned COMP_WINDOW   = 10000;
    localparam int unsigned INIT_DEB_NS   = 100;
    localparam int unsigned INIT_DEB_CYC  = (INIT_DEB_NS * CLK_MHZ + 999) / 1000;
    localparam logic [4:0]  GEAR_LAST     = 5'(GEAR_PERIOD - 1);
    localparam logic [12:0] COMP_LAST     = 13'(COMP_PERIOD - 1);
    localparam logic [3:0]  COMP_LEN_L    = 4'(COMP_LEN - 1);
    localparam logic [3:0]  DEB_LAST      = 4'(INIT_DEB_CYC - 1);
    localparam logic [4:0]  ZERO5         = 5'h00;
    localparam logic [12:0] ZERO13        = 13'h0000;
    localparam logic [3:0]  ZERO4         = 4'h0;

    typedef enum logic [1:0] {
        SASL_TX_RUN  = 2'b00,
        SASL_TX_COMP = 2'b01,
        SASL_TX_GEAR = 2'b10
    } sasl_tx_e;
endpackage

//--- hw/sasl_fifo.sv
`timescale 1ns/1ps
module sasl_fifo #(
    parameter int unsigned WIDTH = 64,
    parameter int unsigned DEPTH = 32
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             ce_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready_out  = (count != (AW+1)'(DEPTH));
    assign out_valid_out = (count != '0);
    assign out_data_out  = mem[rd_ptr];
    assign push          = ce_in && in_valid_in && in_ready_out;
    assign pop           = ce_in && out_valid_out && out_ready_in;

    always_comb begin
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = (AW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (AW+1)'(count - 1'b1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // storage has no reset; words are only read once counted
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end
endmodule // sasl_fifo

//--- hw/sasl_stream_link.sv
`timescale 1ns/1ps
module sasl_stream_link (
    // clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         rst_b_in,
    input  wire logic                         ce_in,
    // control and status
    input  wire logic                         pma_init_in,
    input  wire logic                         clk_not_locked_in,
    output logic                              clk_not_locked_out,
    output logic                              link_reset_out,
    // user transmit stream
    input  wire logic                         tx_valid_in,
    output logic                              tx_ready_out,
    input  wire logic [sasl_pkg::DATA_W-1:0]  tx_data_in,
    // lane transmit
    output logic [sasl_pkg::BLK_W-1:0]        lane_tx_block_out,
    output logic                              lane_tx_valid_out,
    // lane receive
    input  wire logic [sasl_pkg::BLK_W-1:0]   lane_rx_block_in,
    input  wire logic                         lane_rx_valid_in,
    // user receive stream
    output logic                              rx_valid_out,
    output logic [sasl_pkg::DATA_W-1:0]       rx_data_out
);
    // ************************************************************
    // init request: sync, debounce, clock helper status
    // ************************************************************
    logic       init_s1;
    logic       init_s2;
    logic       init_deb;
    logic [3:0] deb_cnt;
    logic       lock_s1;
    logic       lock_s2;
    logic       next_init_deb;
    logic [3:0] next_deb_cnt;

    always_comb begin
        next_init_deb = init_deb;
        next_deb_cnt  = deb_cnt;
        if (init_s2 == init_deb) begin
            next_deb_cnt = sasl_pkg::ZERO4;
        end else if (deb_cnt == sasl_pkg::DEB_LAST) begin
            next_init_deb = init_s2;
            next_deb_cnt  = sasl_pkg::ZERO4;
        end else begin
            next_deb_cnt = 4'(deb_cnt + 1'b1);
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            init_s1  <= 1'b1;
            init_s2  <= 1'b1;
            init_deb <= 1'b1;
            deb_cnt  <= sasl_pkg::ZERO4;
            lock_s1  <= 1'b1;
            lock_s2  <= 1'b1;
        end else if (ce_in) begin
            init_s1  <= pma_init_in;
            init_s2  <= init_s1;
            init_deb <= next_init_deb;
            deb_cnt  <= next_deb_cnt;
            lock_s1  <= clk_not_locked_in;
            lock_s2  <= lock_s1;
        end
    end

    logic run;
    // relies on the input being the inverse of pll lock
    assign clk_not_locked_out = lock_s2;
    assign link_reset_out     = init_deb | lock_s2;
    assign run                = !link_reset_out;

    // ************************************************************
    // transmit scheduler
    // ************************************************************
    sasl_pkg::sasl_tx_e     st;
    sasl_pkg::sasl_tx_e     next_st;
    logic [4:0]             gear_cnt;
    logic [12:0]            comp_cnt;
    logic [3:0]             comp_len;
    logic [4:0]             next_gear_cnt;
    logic [12:0]            next_comp_cnt;
    logic [3:0]             next_comp_len;

    logic                   f_valid;
    logic                   f_ready;
    logic [sasl_pkg::DATA_W-1:0] f_data;
    logic                   fifo_in_ready;

    always_comb begin
        next_st       = st;
        next_gear_cnt = (gear_cnt == sasl_pkg::GEAR_LAST) ? sasl_pkg::ZERO5
                                                          : 5'(gear_cnt + 1'b1);
        next_comp_cnt = (comp_cnt == sasl_pkg::COMP_LAST) ? sasl_pkg::ZERO13
                                                          : 13'(comp_cnt + 1'b1);
        next_comp_len = comp_len;
        unique case (st)
            sasl_pkg::SASL_TX_RUN: begin
                if (comp_cnt == sasl_pkg::COMP_LAST) begin
                    next_st       = sasl_pkg::SASL_TX_COMP;
                    next_comp_len = sasl_pkg::ZERO4;
                end else if (gear_cnt == sasl_pkg::GEAR_LAST) begin
                    next_st = sasl_pkg::SASL_TX_GEAR;
                end
            end
            sasl_pkg::SASL_TX_COMP: begin
                // full eight-cycle burst exceeds three per window
                next_comp_len = 4'(comp_len + 1'b1);
                if (comp_len == sasl_pkg::COMP_LEN_L) begin
                    next_st = sasl_pkg::SASL_TX_RUN;
                end
            end
            sasl_pkg::SASL_TX_GEAR: begin
                next_st = sasl_pkg::SASL_TX_RUN;
            end
            default: begin
                next_st = sasl_pkg::SASL_TX_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st       <= sasl_pkg::SASL_TX_RUN;
            gear_cnt <= sasl_pkg::ZERO5;
            comp_cnt <= sasl_pkg::ZERO13;
            comp_len <= sasl_pkg::ZERO4;
        end else if (ce_in) begin
            if (!run) begin
                st       <= sasl_pkg::SASL_TX_RUN;
                gear_cnt <= sasl_pkg::ZERO5;
                comp_cnt <= sasl_pkg::ZERO13;
                comp_len <= sasl_pkg::ZERO4;
            end else begin
                st       <= next_st;
                gear_cnt <= next_gear_cnt;
                comp_cnt <= next_comp_cnt;
                comp_len <= next_comp_len;
            end
        end
    end

    // ready drops on the gearbox slot; fifo pushes only on valid and ready
    // ready is gated by the enable so that no beat is offered on a frozen edge
    assign tx_ready_out = ce_in && run && fifo_in_ready && (gear_cnt != sasl_pkg::GEAR_LAST);

    sasl_fifo #(
        .WIDTH (sasl_pkg::DATA_W),
        .DEPTH (sasl_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in        (clk_in),
        .rst_b_in      (rst_b_in),
        .ce_in         (ce_in),
        .in_valid_in   (tx_valid_in && tx_ready_out),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (tx_data_in),
        .out_valid_out (f_valid),
        .out_ready_in  (f_ready),
        .out_data_out  (f_data)
    );

    // single lane: one block per cycle, so a data block can directly trail an idle
    // data only in run state
    assign f_ready = run && (st == sasl_pkg::SASL_TX_RUN);

    logic [sasl_pkg::BLK_W-1:0] next_blk;
    logic                       next_blk_v;

    // frames are not built here: streaming only, so no frame end is ever marked
    // no separators in streaming; idle for each gap
    always_comb begin
        next_blk_v = run;
        next_blk   = {sasl_pkg::HDR_CTRL, sasl_pkg::BT_IDLE, 56'h0};
        if (st == sasl_pkg::SASL_TX_COMP) begin
            next_blk = {sasl_pkg::HDR_CTRL, sasl_pkg::BT_COMP, 56'h0};
        end else if (f_ready && f_valid) begin
            next_blk = {sasl_pkg::HDR_DATA, f_data};
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            lane_tx_block_out <= '0;
            lane_tx_valid_out <= 1'b0;
        end else if (ce_in) begin
            lane_tx_block_out <= next_blk;
            lane_tx_valid_out <= next_blk_v;
        end
    end

    // ************************************************************
    // receive
    // ************************************************************
    logic                        next_rx_valid;
    logic [sasl_pkg::DATA_W-1:0] next_rx_data;

    // valid per data block; no ready exists
    always_comb begin
        next_rx_valid = run && lane_rx_valid_in &&
                        (lane_rx_block_in[sasl_pkg::BLK_W-1 -: 2] == sasl_pkg::HDR_DATA);
        next_rx_data  = next_rx_valid ? lane_rx_block_in[sasl_pkg::DATA_W-1:0] : rx_data_out;
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_valid_out <= 1'b0;
            rx_data_out  <= '0;
        end else if (ce_in) begin
            rx_valid_out <= next_rx_valid;
            rx_data_out  <= next_rx_data;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_gear_drop;
        @(posedge clk_in) disable iff (!rst_b_in || !ce_in || !run)
        (gear_cnt == sasl_pkg::GEAR_LAST) |-> !tx_ready_out;
    endproperty
    a_gear_drop: assert property (p_gear_drop) else $error("ready high in gear slot");

    property p_comp_burst;
        @(posedge clk_in) disable iff (!rst_b_in || !ce_in || !run)
        $rose(st == sasl_pkg::SASL_TX_COMP) |-> (st == sasl_pkg::SASL_TX_COMP) [*8]
            ##1 (st != sasl_pkg::SASL_TX_COMP);
    endproperty
    a_comp_burst: assert property (p_comp_burst) else $error("comp burst not 8");

    property p_no_data_in_comp;
        @(posedge clk_in) disable iff (!rst_b_in || !ce_in)
        (st != sasl_pkg::SASL_TX_RUN)
            |=> (lane_tx_block_out[sasl_pkg::BLK_W-1 -: 2] != sasl_pkg::HDR_DATA);
    endproperty
    a_no_data_in_comp: assert property (p_no_data_in_comp) else $error("data in ctrl cycle");

    property p_comp_block;
        @(posedge clk_in) disable iff (!rst_b_in || !ce_in)
        (st == sasl_pkg::SASL_TX_COMP)
            |=> (lane_tx_block_out == {sasl_pkg::HDR_CTRL, sasl_pkg::BT_COMP, 56'h0});
    endproperty
    a_comp_block: assert property (p_comp_block) else $error("comp block missing");

    property p_rx_ctrl_drop;
        @(posedge clk_in) disable iff (!rst_b_in || !ce_in)
        (lane_rx_block_in[sasl_pkg::BLK_W-1 -: 2] != sasl_pkg::HDR_DATA) |=> !rx_valid_out;
    endproperty
    a_rx_ctrl_drop: assert property (p_rx_ctrl_drop) else $error("rx valid on ctrl block");

    property p_rx_valid;
        @(posedge clk_in) disable iff (!rst_b_in || !ce_in || !run)
        (lane_rx_valid_in && lane_rx_block_in[sasl_pkg::BLK_W-1 -: 2] == sasl_pkg::HDR_DATA)
            |=> rx_valid_out && rx_data_out == $past(lane_rx_block_in[sasl_pkg::DATA_W-1:0]);
    endproperty
    a_rx_valid: assert property (p_rx_valid) else $error("rx word lost");
endmodule // sasl_stream_link

//--- dv/sasl_user_model.sv
`timescale 1ns/1ps
module sasl_user_model (
    // clock, reset, traffic enable
    input  wire logic                       clk_in,
    input  wire logic                       rst_b_in,
    input  wire logic                       en_in,
    // transmit stream toward the core
    input  wire logic                       tx_ready_in,
    output logic                            tx_valid_out,
    output logic [sasl_pkg::DATA_W-1:0]     tx_data_out
);
    // ************************************************************
    // beat source
    // ************************************************************
    // hold until taken
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_valid_out <= 1'b0;
            tx_data_out  <= '0;
        end else if (!tx_valid_out || tx_ready_in) begin
            tx_valid_out <= en_in && ($urandom_range(3, 0) != 0);
            tx_data_out  <= {$urandom, $urandom};
        end
    end
endmodule // sasl_user_model

//--- dv/sasl_stream_link_bench.sv
`timescale 1ns/1ps
module sasl_stream_link_bench;
    // ************************************************************
    // signals
    // ************************************************************
    logic                          clk, rst_b, ce, en, init, nlock, p;
    logic                          tx_valid, tx_ready, lane_valid, rx_valid, nlock_out, lreset;
    logic [sasl_pkg::DATA_W-1:0]   tx_data, rx_data;
    logic [sasl_pkg::BLK_W-1:0]    lane_blk, blk0;
    // accept edge, lane register, rx register, then the monitor edge
    localparam int                 RX_LAT = 3;
    logic [sasl_pkg::DATA_W-1:0]   exp_q[$];
    int                            acc_q[$];
    int                            cyc, errors, n_checks, run, cstart, nstart, ctot, nsep;
    int                            k, ak, lows, dbl;

    // lanes looped back so every sent word must come home
    sasl_stream_link sasl_stream_link_inst (
        .clk_in(clk), .rst_b_in(rst_b), .ce_in(ce),
        .pma_init_in(init), .clk_not_locked_in(nlock),
        .clk_not_locked_out(nlock_out), .link_reset_out(lreset),
        .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .tx_data_in(tx_data),
        .lane_tx_block_out(lane_blk), .lane_tx_valid_out(lane_valid),
        .lane_rx_block_in(lane_blk), .lane_rx_valid_in(lane_valid),
        .rx_valid_out(rx_valid), .rx_data_out(rx_data));
    sasl_user_model sasl_user_model_inst (
        .clk_in(clk), .rst_b_in(rst_b), .en_in(en),
        .tx_ready_in(tx_ready), .tx_valid_out(tx_valid), .tx_data_out(tx_data));

    // one clock only: no double-rate sync clock reaches this block
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic is_t(input logic [65:0] b, input logic [7:0] t);
        return b[65:64] == sasl_pkg::HDR_CTRL && (b[7:0] == t || b[63:56] == t);
    endfunction

    task automatic check(input logic [65:0] seen, input logic [65:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic wait_up();
        for (int i = 0; i < 60 && lreset !== 1'b0; i++) @(negedge clk);
        check(lreset, 1'b0);
    endtask

    // ************************************************************
    // monitor
    // ************************************************************
    always @(posedge clk) begin
        cyc++;
        if (tx_valid && tx_ready) begin
            exp_q.push_back(tx_data);
            acc_q.push_back(cyc);
        end
        // receiver has no stall, every word shown on an enabled edge is taken
        if (rx_valid && ce) begin
            if (exp_q.size() == 0) begin
                check(1'b1, 1'b0);
            end else begin
                check(rx_data, exp_q.pop_front());
                ak = acc_q.pop_front();
                if (nstart == 0) check(cyc - ak, RX_LAT);
            end
        end
        if (lane_valid && is_t(lane_blk, sasl_pkg::BT_SEP)) nsep++;
        if (lane_valid && is_t(lane_blk, sasl_pkg::BT_COMP)) begin
            if (run == 0 && nstart > 0) check(cyc - cstart, sasl_pkg::COMP_PERIOD);
            if (run == 0) begin
                cstart = cyc;
                nstart++;
            end
            run++;
            ctot++;
        end else if (run != 0) begin
            check(run, sasl_pkg::COMP_LEN);
            run = 0;
        end
        // ceiling well above the ~11k cycles the sequence needs
        if (cyc == 20000) begin
            errors++;
            tally_and_finish();
        end
    end

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        rst_b = 1'b0; en = 1'b0; init = 1'b0; nlock = 1'b0;
        ce = 1'b1;
        cyc = 0; errors = 0; n_checks = 0; run = 0; nstart = 0; ctot = 0; nsep = 0;
        void'($urandom(32'hc2dc65b4));
        repeat (6) @(posedge clk);
        check(nlock_out, 1'b1);
        check(lreset, 1'b1);
        check(tx_ready, 1'b0);
        rst_b <= 1'b1;
        wait_up();
        check(nlock_out, 1'b0);
        @(posedge clk);
        en <= 1'b1;
        lows = 0; dbl = 0; p = 1'b1;
        repeat (320) begin
            @(negedge clk);
            lows += (tx_ready === 1'b0);
            dbl += (tx_ready === 1'b0 && p === 1'b0);
            p = tx_ready;
        end
        check(lows, 10);
        check(dbl, 0);
        // long enough for two compensation bursts
        repeat (10400) @(posedge clk);
        en <= 1'b0;
        repeat (20) @(posedge clk);
        check(exp_q.size(), 0);
        check(nstart >= 2, 1'b1);
        check(ctot >= sasl_pkg::COMP_MIN, 1'b1);
        check(nsep, 0);
        // short init glitch must be filtered out
        init <= 1'b1;
        repeat (3) @(posedge clk);
        init <= 1'b0;
        lows = 0;
        repeat (20) begin
            @(negedge clk);
            lows += (lreset !== 1'b0);
        end
        check(lows, 0);
        @(posedge clk);
        init <= 1'b1;
        repeat (30) @(posedge clk);
        check(lreset, 1'b1);
        init <= 1'b0;
        wait_up();
        @(posedge clk);
        // nlock plays the inverted pll lock: lock is lost here
        nlock <= 1'b1;
        repeat (10) @(posedge clk);
        check(nlock_out, 1'b1);
        check(lreset, 1'b1);
        nlock <= 1'b0;
        wait_up();
        @(posedge clk);
        en <= 1'b1;
        repeat (200) @(posedge clk);
        en <= 1'b0;
        repeat (20) @(posedge clk);
        check(exp_q.size(), 0);
        // enable low freezes the block under live traffic, then traffic resumes
        en <= 1'b1;
        repeat (50) @(posedge clk);
        ce <= 1'b0;
        @(negedge clk);
        blk0 = lane_blk; k = 0; lows = 0;
        repeat (10) begin
            @(negedge clk);
            k += (lane_blk !== blk0);
            lows += (tx_ready !== 1'b0);
        end
        check(k, 0);
        check(lows, 0);
        check(lreset, 1'b0);
        @(posedge clk);
        ce <= 1'b1;
        repeat (100) @(posedge clk);
        en <= 1'b0;
        repeat (20) @(posedge clk);
        check(exp_q.size(), 0);
        tally_and_finish();
    end
endmodule // sasl_stream_link_bench
